// file: core/srdc_divider.sv
// Purpose: four serial sysref divide stages driven from clk_sys
// Assumes: divider field stable while running
// Notes: output is a one-cycle pulse per full division period
`timescale 1ns/10ps
module srdc_divider (
   input wire logic clk_sys,
   input wire logic reset,
   input wire logic powerdown,     // stops and clears all stages
   input wire logic [6:0] field,   // sysref_freq_divider
   output logic tick               // one pulse per total ratio cycles
);

   logic [4:0] ratio [4];          // per stage ratio
   logic [4:0] en_w;               // en_w[0] is the input rate, en_w[4] the output

   // ***************************************
   // stage ratio decode
   // ***************************************
   always_comb begin
      ratio[0] = field[6] ? 5'h04 : 5'h02;              // RL3
      ratio[1] = 5'h02 << field[5:4];                   // RL4
      ratio[2] = 5'h02 << field[3:2];                   // RL4
      ratio[3] = 5'h02 + {3'h0, field[1:0]};            // RL5
   end

   assign en_w[0] = 1'b1;          // input tick every clk_sys cycle

   // ***************************************
   // serial chain
   // ***************************************
   // each stage counts ticks of the one before, so ratios multiply
   genvar gi;
   generate
      for (gi = 0; gi < 4; gi++) begin : g_stage
         srdc_stage #(.RW(5)) u_stage (      // RL2
            .clk_sys(clk_sys),
            .reset(reset),
            .clear(powerdown),               // RL9
            .en_in(en_w[gi]),
            .ratio(ratio[gi]),
            .en_out(en_w[gi+1])
         );
      end
   endgenerate

   assign tick = en_w[4];

endmodule : srdc_divider

// file: core/srdc_pkg.sv
// Purpose: constants and types shared by the sysref divider control block
// Assumes: one clock clk_sys at 200 MHz, synchronous active high reset
// Notes: register offsets are byte addresses on an avalon-mm word bus
// Function
// (RL1) power-down bit stops all sysref blocks
// (RL2) four serial stages, ratios multiply together
// (RL3) stage one: bit 6 gives /2 or /4
// (RL4) stages two, three: /2 /4 /8 /16
// (RL5) stage four: /2 /3 /4 /5
// (RL6) reset: divider 0101111 (/1280), power-down 0
// (RL7) software prefers largest ratio in low stage
// (RL8) map: sysref_divider_ctrl pd+divider, sysref_generation_ctrl gen/out, sysref_aux_ctrl aux
// (RL9) power-down holds stages in known reset
package srdc_pkg;

   // ***************************************
   // register map
   // ***************************************
   localparam logic [7:0] SRDC_DIV_OFS = 8'h18;   // pd bit and divider field
   localparam logic [7:0] SRDC_REL_OFS = 8'h19;   // release control
   localparam logic [7:0] SRDC_PCNT_OFS = 8'h1A;  // pulse count
   localparam logic [7:0] SRDC_PHASE_OFS = 8'h1B; // global phase
   localparam logic [7:0] SRDC_GEN_OFS = 8'h1C;   // generate and output select
   localparam logic [7:0] SRDC_AUX_OFS = 8'h70;   // aux control
   localparam logic [7:0] SRDC_STAT_OFS = 8'h74;  // divider status (read only)

   // ***************************************
   // field positions and reset values
   // ***************************************
   localparam int SRDC_PD_BIT = 7;
   localparam int SRDC_GEN_BIT = 1;
   localparam int SRDC_OSEL_BIT = 0;
   localparam int SRDC_AUX_BIT = 7;
   localparam logic [7:0] SRDC_DIV_RST = 8'h2F;   // /1280, powered up
   localparam logic [7:0] SRDC_REL_RST = 8'h81;
   localparam logic [7:0] SRDC_ZERO_RST = 8'h00;
   localparam logic [7:0] SRDC_GEN_MASK = 8'h03;  // reserved bits read zero
   localparam logic [7:0] SRDC_AUX_MASK = 8'h80;
   localparam logic [31:0] SRDC_UNMAPPED = 32'h00000000;

   // ***************************************
   // carried groups
   // ***************************************
   typedef struct packed {
      logic [7:0] address;
      logic read;
      logic write;
      logic [31:0] writedata;
   } srdc_req_type;

   typedef struct packed {
      logic sysref_global_powerdown;
      logic [6:0] sysref_freq_divider;
   } srdc_cfg_type;

endpackage : srdc_pkg

// file: core/srdc_stage.sv
// Purpose: one programmable divide stage, enable in, enable pulse out
// Assumes: ratio is at least 2 and fits RW bits
// Notes: a held clear restarts the count from zero
`timescale 1ns/10ps
module srdc_stage #(
   parameter int RW = 5
) (
   input wire logic clk_sys,
   input wire logic reset,
   input wire logic clear,         // holds the stage in its known state
   input wire logic en_in,         // one-cycle input tick
   input wire logic [RW-1:0] ratio,
   output logic en_out             // one-cycle output tick
);

   logic [RW-1:0] cnt_q;           // ticks seen in this period

   // ***************************************
   // counter
   // ***************************************
   // count input ticks, emit one per ratio ticks
   always_ff @(posedge clk_sys) begin
      if (reset || clear) begin
         cnt_q <= '0;
         en_out <= 1'b0;
      end else begin
         en_out <= 1'b0;
         if (en_in) begin
            // wrap at ratio-1; a ratio changed mid-period applies at the next input tick, wrapping at once if cnt_q is past it
            if (cnt_q >= ratio - RW'(1)) begin
               cnt_q <= '0;
               en_out <= 1'b1;
            end else begin
               cnt_q <= cnt_q + RW'(1);
            end
         end
      end
   end

endmodule : srdc_stage

// file: core/srdc_top.sv
// Purpose: sysref control registers with the sysref frequency divider
// Assumes: avalon-mm slave, 32-bit data, byte addresses, one clock
// Notes: one wait state on every access; unmapped reads return zero
//
// Register access over Avalon-MM is this design's own decision.
`timescale 1ns/10ps
module srdc_top (
   input wire logic clk_sys,
   input wire logic reset,
   input wire logic [7:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   output logic sysref_global_powerdown,    // sysref blocks powered down
   output logic [6:0] sysref_freq_divider,
   output logic sysref_generate_bit,
   output logic sysref_output_select_bit,
   output logic sysref_aux_bit,
   output logic [7:0] sysref_release_q_out,
   output logic [7:0] sysref_pulse_count,
   output logic [7:0] sysref_global_phase,
   output logic sysref_tick                 // divided sysref rate pulse
);

   srdc_pkg::srdc_req_type req;
   srdc_pkg::srdc_cfg_type cfg_q;           // pd and divider field
   logic [7:0] rel_q;
   logic [7:0] pcnt_q;
   logic [7:0] phase_q;
   logic [7:0] gen_q;
   logic [7:0] aux_q;
   logic ack_q;                             // access completes this cycle
   logic div_tick;
   logic [7:0] tick_cnt_q;                  // status: divided ticks seen
   logic wr_lane0;

   // ***************************************
   // bus request
   // ***************************************
   assign req.address = avs_address;
   assign req.read = avs_read;
   assign req.write = avs_write;
   assign req.writedata = avs_writedata;
   assign wr_lane0 = req.write && avs_byteenable[0] && !ack_q;

   // waitrequest is a flop: high while idle and in the first request cycle,
   // low in the second; idle high also keeps anything from completing in reset
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         ack_q <= 1'b0;
         avs_waitrequest <= 1'b1;
      end else begin
         ack_q <= (req.read || req.write) && !ack_q;
         avs_waitrequest <= !((req.read || req.write) && !ack_q);
      end
   end

   // ***************************************
   // registers
   // ***************************************
   // writes land on the first request cycle; byte lane 0 only
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         cfg_q <= srdc_pkg::SRDC_DIV_RST;                  // RL6
         rel_q <= srdc_pkg::SRDC_REL_RST;
         pcnt_q <= srdc_pkg::SRDC_ZERO_RST;
         phase_q <= srdc_pkg::SRDC_ZERO_RST;
         gen_q <= srdc_pkg::SRDC_ZERO_RST;
         aux_q <= srdc_pkg::SRDC_ZERO_RST;
      end else if (wr_lane0) begin
         unique case (req.address)                         // RL8
            srdc_pkg::SRDC_DIV_OFS: begin
               cfg_q <= req.writedata[7:0];
            end
            srdc_pkg::SRDC_REL_OFS: begin
               rel_q <= req.writedata[7:0];
            end
            srdc_pkg::SRDC_PCNT_OFS: begin
               pcnt_q <= req.writedata[7:0];
            end
            srdc_pkg::SRDC_PHASE_OFS: begin
               phase_q <= req.writedata[7:0];
            end
            srdc_pkg::SRDC_GEN_OFS: begin
               gen_q <= req.writedata[7:0] & srdc_pkg::SRDC_GEN_MASK;
            end
            srdc_pkg::SRDC_AUX_OFS: begin
               aux_q <= req.writedata[7:0] & srdc_pkg::SRDC_AUX_MASK;
            end
            default: begin
               // unmapped writes are dropped
            end
         endcase
      end
   end

   // read data registered on the first cycle, valid with waitrequest low
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         avs_readdata <= srdc_pkg::SRDC_UNMAPPED;
      end else if (req.read && !ack_q) begin
         unique case (req.address)
            srdc_pkg::SRDC_DIV_OFS: avs_readdata <= {24'h000000, cfg_q};
            srdc_pkg::SRDC_REL_OFS: avs_readdata <= {24'h000000, rel_q};
            srdc_pkg::SRDC_PCNT_OFS: avs_readdata <= {24'h000000, pcnt_q};
            srdc_pkg::SRDC_PHASE_OFS: avs_readdata <= {24'h000000, phase_q};
            srdc_pkg::SRDC_GEN_OFS: avs_readdata <= {24'h000000, gen_q};
            srdc_pkg::SRDC_AUX_OFS: avs_readdata <= {24'h000000, aux_q};
            srdc_pkg::SRDC_STAT_OFS: avs_readdata <= {24'h000000, tick_cnt_q};
            default: avs_readdata <= srdc_pkg::SRDC_UNMAPPED;
         endcase
      end
   end

   // ***************************************
   // divider
   // ***************************************
   // powered down stages are held cleared so restart phase is known
   srdc_divider u_div (
      .clk_sys(clk_sys),
      .reset(reset),
      .powerdown(cfg_q.sysref_global_powerdown),           // RL1 RL9
      .field(cfg_q.sysref_freq_divider),
      .tick(div_tick)
   );

   // status counter shows the divider is alive; cleared in power-down
   always_ff @(posedge clk_sys) begin
      if (reset || cfg_q.sysref_global_powerdown) begin    // RL1
         tick_cnt_q <= 8'h00;
      end else if (div_tick) begin
         tick_cnt_q <= tick_cnt_q + 8'h01;
      end
   end

   // ***************************************
   // registered outputs
   // ***************************************
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         sysref_global_powerdown <= 1'b0;
         sysref_freq_divider <= srdc_pkg::SRDC_DIV_RST[6:0];   // RL6
         sysref_generate_bit <= 1'b0;
         sysref_output_select_bit <= 1'b0;
         sysref_aux_bit <= 1'b0;
         sysref_release_q_out <= srdc_pkg::SRDC_REL_RST;
         sysref_pulse_count <= srdc_pkg::SRDC_ZERO_RST;
         sysref_global_phase <= srdc_pkg::SRDC_ZERO_RST;
         sysref_tick <= 1'b0;
      end else begin
         sysref_global_powerdown <= cfg_q.sysref_global_powerdown;  // RL1
         sysref_freq_divider <= cfg_q.sysref_freq_divider;
         sysref_generate_bit <= gen_q[srdc_pkg::SRDC_GEN_BIT];
         sysref_output_select_bit <= gen_q[srdc_pkg::SRDC_OSEL_BIT];
         sysref_aux_bit <= aux_q[srdc_pkg::SRDC_AUX_BIT];
         sysref_release_q_out <= rel_q;
         sysref_pulse_count <= pcnt_q;
         sysref_global_phase <= phase_q;
         sysref_tick <= div_tick && !cfg_q.sysref_global_powerdown;
      end
   end

endmodule : srdc_top

// file: test/srdc_chk_sva.sv
// Purpose: concurrent checks on the sysref divider control ports
// Assumes: one clock clk_sys, synchronous active high reset
// Notes: the tick period is judged only after a whole period on a steady field
`timescale 1ns/10ps
module srdc_chk (
   input wire logic clk_sys,
   input wire logic reset,
   input wire logic [7:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   input wire logic [31:0] avs_readdata,
   input wire logic avs_waitrequest,
   input wire logic sysref_global_powerdown,
   input wire logic [6:0] sysref_freq_divider,
   input wire logic sysref_generate_bit,
   input wire logic sysref_output_select_bit,
   input wire logic sysref_aux_bit,
   input wire logic sysref_tick
);
   // ***************************************
   // helper logic
   // ***************************************
   logic [12:0] cnt_q;   // cycles since the last tick; the longest ratio needs 13 bits
   logic [1:0] ok_q;     // ticks seen since the field last changed, held at 2
   logic [6:0] div_q;    // field one cycle ago
   int ratio;            // total ratio of the present field
   assign ratio = (sysref_freq_divider[6] ? 4 : 2) * (2 << sysref_freq_divider[5:4])
      * (2 << sysref_freq_divider[3:2]) * (sysref_freq_divider[1:0] + 2);
   // count restarts on each tick and while powered down
   always_ff @(posedge clk_sys) begin
      if (reset || sysref_tick || sysref_global_powerdown) begin
         cnt_q <= 13'h0000;
      end else begin
         cnt_q <= cnt_q + 13'h0001;
      end
   end
   // a field change mixes old and new ratios; the first tick after it may still
   // end a chain launched on the old field, so judging starts after the second
   always_ff @(posedge clk_sys) begin
      div_q <= sysref_freq_divider;
      if (reset || sysref_global_powerdown || sysref_freq_divider != div_q) begin
         ok_q <= 2'h0;
      end else if (sysref_tick && ok_q != 2'h2) begin
         ok_q <= ok_q + 2'h1;
      end
   end
   // ***************************************
   // assertions
   // ***************************************
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (reset);
   sequence s_take;
      (avs_read || avs_write) && avs_waitrequest;
   endsequence
   sequence s_wr(ofs);
      avs_write && avs_waitrequest && avs_address == ofs && avs_byteenable[0];
   endsequence
   AST_ONE_WAIT: assert property (s_take |=> !avs_waitrequest)
      else $error("access not done after one wait state");
   AST_RESET_VAL: assert property ($fell(reset) |-> sysref_freq_divider == 7'h2F
      && !sysref_global_powerdown) else $error("wrong divider value after reset");
   // the register lands at the taking edge and the output flop follows one edge later
   AST_DIV_WRITE: assert property (s_wr(8'h18) |-> ##2
      {sysref_global_powerdown, sysref_freq_divider} == $past(avs_writedata[7:0], 2))
      else $error("divider register write lost");
   AST_CFG_HOLD: assert property (!(avs_write && avs_waitrequest && avs_byteenable[0]
      && avs_address == 8'h18) |-> ##2 $stable({sysref_global_powerdown, sysref_freq_divider}))
      else $error("divider register changed without a write");
   AST_GEN_WRITE: assert property (s_wr(8'h1C) |-> ##2
      {sysref_generate_bit, sysref_output_select_bit} == $past(avs_writedata[1:0], 2))
      else $error("generation bits write lost");
   AST_AUX_WRITE: assert property (s_wr(8'h70) |-> ##2
      sysref_aux_bit == $past(avs_writedata[7], 2))
      else $error("aux bit write lost");
   AST_RD_DIV: assert property (avs_read && !avs_waitrequest && avs_address == 8'h18 |->
      avs_readdata == {24'h000000, sysref_global_powerdown, sysref_freq_divider})
      else $error("divider register read wrong");
   AST_PD_QUIET: assert property (sysref_global_powerdown && $past(sysref_global_powerdown)
      |-> !sysref_tick) else $error("tick while powered down");
   AST_PERIOD: assert property (ok_q == 2'h2 && !sysref_global_powerdown
      && sysref_freq_divider == div_q |-> sysref_tick == (cnt_q == ratio - 1))
      else $error("tick period differs from stage product");
endmodule : srdc_chk

// file: test/test_sysref_divider_control.sv
// Purpose: self-checking bench for the sysref divider control block
// Assumes: avalon-mm master keeps each request until waitrequest is low
// Notes: the first two tick gaps after a field change may be mixed and are not judged
`timescale 1ns/10ps
module test_sysref_divider_control;
   logic clk_sys, reset, pd, gen, osel, aux, tick;
   srdc_pkg::srdc_req_type req;   // request bundle driven by the bus task
   logic [3:0] be_q;
   logic [31:0] avs_readdata;
   logic avs_waitrequest;
   logic [6:0] div;
   logic [7:0] rel, pcnt, phase;
   int error_cnt, num_checks, n;
   logic [31:0] r;
   logic [6:0] fl [6] = '{7'h00, 7'h15, 7'h2A, 7'h3F, 7'h40, 7'h12};  // every stage code
   srdc_top i_srdc_top (.clk_sys(clk_sys), .reset(reset), .avs_address(req.address),
      .avs_read(req.read), .avs_write(req.write), .avs_writedata(req.writedata),
      .avs_byteenable(be_q), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
      .sysref_global_powerdown(pd), .sysref_freq_divider(div), .sysref_generate_bit(gen),
      .sysref_output_select_bit(osel), .sysref_aux_bit(aux), .sysref_release_q_out(rel),
      .sysref_pulse_count(pcnt), .sysref_global_phase(phase), .sysref_tick(tick));
   // ***************************************
   // shared tasks
   // ***************************************
   task check(input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         error_cnt++;
         $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   task conclude;
      if (error_cnt == 0 && num_checks > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask : conclude
   task hang;
      error_cnt++;
      $display("[FAIL] %0t wait ran out", $time);
      conclude();
   endtask : hang
   // one access; the request stands until waitrequest is seen low at an edge
   task av(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] b);
      logic ws;
      @(posedge clk_sys);
      req <= '{a, !w, w, d};
      be_q <= b;
      for (int i = 0; i < 20; i++) begin
         @(negedge clk_sys);
         ws = avs_waitrequest;
         r = avs_readdata;
         @(posedge clk_sys);
         if (ws === 1'b0) break;
      end
      if (ws !== 1'b0) hang();
      req <= '{a, 1'b0, 1'b0, d};
   endtask : av
   task rd_chk(input logic [7:0] a, input logic [31:0] e);
      av(1'b0, a, 32'h00000000, 4'hF);
      check(r, e);
   endtask : rd_chk
   // cycles until the next tick, bounded well above the longest mixed period
   task tick_gap;
      n = 0;
      do begin
         @(negedge clk_sys);
         n++;
      end while (tick !== 1'b1 && n < 6000);
      if (tick !== 1'b1) hang();
   endtask : tick_gap
   function automatic int ratio(input logic [6:0] f);
      return (f[6] ? 4 : 2) * (2 << f[5:4]) * (2 << f[3:2]) * (f[1:0] + 2);
   endfunction : ratio
   // ***************************************
   // scenarios
   // ***************************************
   task t_reset;
      check({pd, div}, 32'h2F);
      check(rel, srdc_pkg::SRDC_REL_RST);
      rd_chk(8'h18, 32'h0000002F);
      rd_chk(8'h19, 32'h00000081);
      tick_gap();
      tick_gap();
      check(n, 1280);
   endtask : t_reset
   task t_ratio;
      foreach (fl[i]) begin
         av(1'b1, 8'h18, {25'h0000000, fl[i]}, 4'hF);
         rd_chk(8'h18, {25'h0000000, fl[i]});
         // the first two gaps may still mix the old field, the third is clean
         tick_gap();
         tick_gap();
         tick_gap();
         check(n, ratio(fl[i]));
      end
   endtask : t_ratio
   task t_pd;
      int t;
      av(1'b1, 8'h18, 32'h00000080, 4'hF);
      t = 0;
      repeat (100) begin
         @(negedge clk_sys);
         t += (tick === 1'b1);
      end
      check({pd, t[7:0]}, 32'h100);
      rd_chk(8'h74, 32'h00000000);
      // /16 set as software should: no larger ratio fits the lowest stage
      av(1'b1, 8'h18, 32'h00000000, 4'hF);
      tick_gap();
      // restart: one full period plus the chain's fixed latency of four cycles
      check(n, ratio(7'h00) + 4);
      tick_gap();
      check(n, 16);
   endtask : t_pd
   task t_regs;
      av(1'b1, 8'h1A, 32'h123456C3, 4'hF);
      rd_chk(8'h1A, 32'h000000C3);
      check(pcnt, 8'hC3);
      av(1'b1, 8'h1C, 32'h000000FE, 4'hF);
      rd_chk(8'h1C, 32'h00000002);
      check({gen, osel}, 2'b10);
      av(1'b1, 8'h70, 32'h000000FF, 4'hF);
      rd_chk(8'h70, 32'h00000080);
      check(aux, 1'b1);
      av(1'b1, 8'h1C, 32'h00000001, 4'hF);
      rd_chk(8'h1C, 32'h00000001);
      check({gen, osel}, 2'b01);
      av(1'b1, 8'h1B, 32'h0000005A, 4'hF);
      rd_chk(8'h1B, 32'h0000005A);
      check(phase, 8'h5A);
      av(1'b1, 8'h19, 32'h00000042, 4'hF);
      rd_chk(8'h19, 32'h00000042);
      check(rel, 8'h42);
      av(1'b1, 8'h40, 32'h000000FF, 4'hF);
      rd_chk(8'h40, 32'h00000000);
      av(1'b1, 8'h18, 32'h000000FF, 4'hE);
      rd_chk(8'h18, 32'h00000000);
   endtask : t_regs
   // ***************************************
   // clock and main sequence
   // ***************************************
   initial begin
      clk_sys = 1'b0;
      forever #2.5 clk_sys = ~clk_sys;
   end
   initial begin
      reset = 1'b1;
      req = '0;
      be_q = 4'hF;
      error_cnt = 0;
      num_checks = 0;
      repeat (3) @(posedge clk_sys);
      reset <= 1'b0;
      t_reset();
      t_ratio();
      t_pd();
      t_regs();
      conclude();
   end
endmodule : test_sysref_divider_control
bind srdc_top srdc_chk i_srdc_chk (.clk_sys(clk_sys), .reset(reset),
   .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
   .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
   .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
   .sysref_global_powerdown(sysref_global_powerdown), .sysref_freq_divider(sysref_freq_divider),
   .sysref_generate_bit(sysref_generate_bit), .sysref_output_select_bit(sysref_output_select_bit),
   .sysref_aux_bit(sysref_aux_bit), .sysref_tick(sysref_tick));
